// ---- core/vrc_bus_if.sv ----
`timescale 1ns/1ps
interface vrc_bus_if;
    logic                       wr;
    logic [vrc_pkg::ADDR_W-1:0] adr;
    logic [7:0]                 wdat;
    logic                       wsel;

    modport master (output wr, output adr, output wdat, output wsel);
    modport slave  (input  wr, input  adr, input  wdat, input  wsel);
endinterface : vrc_bus_if

// ---- core/vrc_pkg.sv ----
package vrc_pkg;
    // ***********************************************************
    // Register map (byte addresses on Wishbone)
    // ***********************************************************
    // 0x9F is not a multiple of four, so it is kept as an index
    localparam logic [7:0]  LADDER_CTRL_IDX   = 8'h9F;
    localparam logic [9:0]  LADDER_CTRL_ADDR  = {LADDER_CTRL_IDX, 2'b00};
    localparam logic [9:0]  CMP_MODE_ADDR     = 10'h000;
    localparam logic [9:0]  PORT_DIR_ADDR     = 10'h004;
    localparam logic [9:0]  LADDER_STAT_ADDR  = 10'h008;
    localparam int          ADDR_W            = 10;

    // ***********************************************************
    // Field layout and reset values
    // ***********************************************************
    localparam int          PWR_BIT           = 7;
    localparam int          PIN_OE_BIT        = 6;
    localparam int          RANGE_BIT         = 5;
    localparam int          UNUSED_BIT        = 4;
    localparam int          TAP_W             = 4;
    localparam int          TAP_LEVELS        = 16;
    localparam logic [7:0]  CTRL_WRITE_MASK   = 8'hEF;
    localparam logic [7:0]  CTRL_RESET        = 8'h00;
    localparam logic [2:0]  CMP_MODE_RESET    = 3'h0;
    localparam logic [4:0]  PORT_DIR_RESET    = 5'h1F;
    localparam int          PORT_A_PIN_TWO    = 2;

    typedef enum logic [2:0] {
        VRC_CM_RESET    = 3'b000,
        VRC_CM_VREF     = 3'b010,
        VRC_CM_OFF      = 3'b111
    } vrc_cmp_mode_t;
endpackage : vrc_pkg

// ---- core/vrc_reg.sv ----
`timescale 1ns/1ps
// ***********************************************************
// Ladder control register store
// ***********************************************************
module vrc_reg (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    vrc_bus_if.slave    bus,
    output logic [7:0]  ctrl_o
);
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (bus.wr && bus.wsel && bus.adr == vrc_pkg::LADDER_CTRL_ADDR) begin
            // Bit 4 never stores, so it always reads back as zero
            ctrl_nxt = bus.wdat & vrc_pkg::CTRL_WRITE_MASK;
        end
    end

    // Only device reset clears; sleep wake-up has no path here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= vrc_pkg::CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    assign ctrl_o = ctrl_r;
endmodule : vrc_reg

// ---- core/vrc_top.sv ----
`timescale 1ns/1ps
// Behaviour
// - Sixteen tap levels per range, four-bit code
// - Range bit picks divide-by-24 or quarter-plus-32nds
// - Power bit seven powers ladder, else off
// - Reset clears every implemented control bit
// - Pin drive needs pin-output bit and direction bit
// - Sleep wake-up leaves control register unchanged
// - Bit four ignores writes, reads zero
// - Reference works regardless of comparator mode
// - Comparator mode 010 feeds reference to both (here only the one output cmp_vin_plus_vref_o)
module vrc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             ladder_power_on_o,
    output logic             ladder_range_select_o,
    output logic [3:0]       ladder_tap_select_o,
    output logic             port_a_pin_two_vref_o,
    output logic             cmp_vin_plus_vref_o
);
    // ***********************************************************
    // Bus decode
    // ***********************************************************
    function automatic logic vrc_mapped(input logic [31:0] a);
        return a[31:vrc_pkg::ADDR_W] == '0 &&
               (a[9:0] == vrc_pkg::LADDER_CTRL_ADDR || a[9:0] == vrc_pkg::CMP_MODE_ADDR ||
                a[9:0] == vrc_pkg::PORT_DIR_ADDR || a[9:0] == vrc_pkg::LADDER_STAT_ADDR);
    endfunction : vrc_mapped

    vrc_bus_if bus ();

    logic        req;
    logic        ack_r,   ack_nxt;
    logic        err_r,   err_nxt;
    logic [31:0] dat_r,   dat_nxt;
    logic [2:0]  cmode_r, cmode_nxt;
    logic [4:0]  pdir_r,  pdir_nxt;
    logic        pwr_r,   pwr_nxt;
    logic        rng_r,   rng_nxt;
    logic [3:0]  tap_r,   tap_nxt;
    logic        pin_r,   pin_nxt;
    logic        cvr_r,   cvr_nxt;
    logic [7:0]  ctrl;

    // A new request is only taken while no answer is standing
    assign req       = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
    assign bus.wr    = req && wb_we_i && vrc_mapped(wb_adr_i);
    assign bus.adr   = wb_adr_i[vrc_pkg::ADDR_W-1:0];
    assign bus.wdat  = wb_dat_i[7:0];
    assign bus.wsel  = wb_sel_i[0];

    vrc_reg u_reg (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .bus    (bus),
        .ctrl_o (ctrl)
    );

    // ***********************************************************
    // Answer, read data, side registers
    // ***********************************************************
    always_comb begin
        ack_nxt   = req && vrc_mapped(wb_adr_i);
        err_nxt   = req && !vrc_mapped(wb_adr_i);
        dat_nxt   = 32'h0000_0000;
        cmode_nxt = cmode_r;
        pdir_nxt  = pdir_r;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i[vrc_pkg::ADDR_W-1:0])
                vrc_pkg::LADDER_CTRL_ADDR: dat_nxt = {24'h00_0000, ctrl};
                vrc_pkg::CMP_MODE_ADDR:    dat_nxt = {29'h0, cmode_r};
                vrc_pkg::PORT_DIR_ADDR:    dat_nxt = {27'h0, pdir_r};
                vrc_pkg::LADDER_STAT_ADDR: dat_nxt = {24'h00_0000, pwr_r, pin_r, rng_r,
                                                      cvr_r, tap_r};
                default:                   dat_nxt = 32'h0000_0000;
            endcase
        end
        if (bus.wr && wb_sel_i[0]) begin
            if (bus.adr == vrc_pkg::CMP_MODE_ADDR) begin
                cmode_nxt = wb_dat_i[2:0];
            end
            if (bus.adr == vrc_pkg::PORT_DIR_ADDR) begin
                pdir_nxt = wb_dat_i[4:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            err_r   <= 1'b0;
            dat_r   <= 32'h0000_0000;
            cmode_r <= vrc_pkg::CMP_MODE_RESET;
            pdir_r  <= vrc_pkg::PORT_DIR_RESET;
        end else begin
            ack_r   <= ack_nxt;
            err_r   <= err_nxt;
            dat_r   <= dat_nxt;
            cmode_r <= cmode_nxt;
            pdir_r  <= pdir_nxt;
        end
    end

    // ***********************************************************
    // Ladder controls
    // ***********************************************************
    // Taps decode in the analog ladder: code/24 (range set) or 1/4 + code/32
    always_comb begin
        pwr_nxt = ctrl[vrc_pkg::PWR_BIT];
        rng_nxt = ctrl[vrc_pkg::RANGE_BIT];
        tap_nxt = ctrl[vrc_pkg::TAP_W-1:0];
        pin_nxt = ctrl[vrc_pkg::PIN_OE_BIT] && pdir_r[vrc_pkg::PORT_A_PIN_TWO];
        cvr_nxt = cmode_r == vrc_pkg::VRC_CM_VREF;
    end

    // One cycle behind the register write; settling is left to software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_r <= 1'b0;
            rng_r <= 1'b0;
            tap_r <= 4'h0;
            pin_r <= 1'b0;
            cvr_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            rng_r <= rng_nxt;
            tap_r <= tap_nxt;
            pin_r <= pin_nxt;
            cvr_r <= cvr_nxt;
        end
    end

    assign wb_dat_o              = dat_r;
    assign wb_ack_o              = ack_r;
    assign wb_err_o              = err_r;
    assign ladder_power_on_o     = pwr_r;
    assign ladder_range_select_o = rng_r;
    assign ladder_tap_select_o   = tap_r;
    assign port_a_pin_two_vref_o = pin_r;
    assign cmp_vin_plus_vref_o   = cvr_r;
endmodule : vrc_top

// ---- test/vrc_top_asserts.sv ----
`timescale 1ns/1ps
module vrc_top_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        ladder_power_on_o,
    input wire logic        ladder_range_select_o,
    input wire logic [3:0]  ladder_tap_select_o,
    input wire logic        port_a_pin_two_vref_o,
    input wire logic        cmp_vin_plus_vref_o
);
    localparam logic [31:0] CA = 32'(vrc_pkg::LADDER_CTRL_ADDR);
    localparam logic [31:0] MA = 32'(vrc_pkg::CMP_MODE_ADDR);
    wire logic tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire logic cw = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == CA;
    wire logic mw = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == MA;
    wire logic mapped = wb_adr_i inside {CA, MA, 32'h00000004, 32'h00000008};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ctrl_ack_a: assert property (tk && wb_adr_i == CA |=> wb_ack_o && !wb_err_o)
        else $error("no ack on control access");
    bad_adr_err_a: assert property (tk && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("no err on unmapped access");
    power_bit_a: assert property (cw |=> ladder_power_on_o == $past(wb_dat_i[7]))
        else $error("power output wrong");
    range_bit_a: assert property (cw |=> ladder_range_select_o == $past(wb_dat_i[5]))
        else $error("range output wrong");
    tap_code_a: assert property (cw |=> ladder_tap_select_o == $past(wb_dat_i[3:0]))
        else $error("tap output wrong");
    ctrl_hold_a: assert property (!cw |=> $stable(ladder_tap_select_o) &&
        $stable(ladder_power_on_o)) else $error("ladder changed without write");
    bit4_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == CA |->
        !wb_dat_o[4] && wb_dat_o[7] == ladder_power_on_o) else $error("bad control read");
    cmp_mode_a: assert property (mw |=>
        cmp_vin_plus_vref_o == ($past(wb_dat_i[2:0]) == 3'h2))
        else $error("comparator feed wrong");
    rst_clear_a: assert property (disable iff (1'b0) rst_i |=> !ladder_power_on_o &&
        !ladder_range_select_o && ladder_tap_select_o == 4'h0 && !port_a_pin_two_vref_o)
        else $error("outputs not cleared by reset");
    c_wr: cover property (cw);
    c_err: cover property (wb_err_o);
    c_pin: cover property (port_a_pin_two_vref_o);
endmodule : vrc_top_asserts

bind vrc_top vrc_top_asserts u_chk (.*);

// ---- test/vrc_top_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, x, y) begin check_count++; if ((x) !== (y)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", n, x, y); end end
module vrc_top_tb_top;
    localparam logic [31:0] CA = 32'(vrc_pkg::LADDER_CTRL_ADDR);
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, s0 = 0, e;
    logic [31:0] adr = 0, dat = 0, dat_o;
    logic        ack, err, pwr, rng, pin, cmp, s;
    logic [3:0]  tap;
    logic [7:0]  ctl, dir, cm, rd, v;
    int          fail_count = 0, check_count = 0;

    vrc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i({3'h0, s0}), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .ladder_power_on_o(pwr), .ladder_range_select_o(rng),
        .ladder_tap_select_o(tap), .port_a_pin_two_vref_o(pin), .cmp_vin_plus_vref_o(cmp));

    // ****************
    // Bus and verdict
    // ****************
    // Starts on a fresh edge so a release never shares a time step with the next request
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d, input logic sl);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h0, d};
        s0  <= sl;
        // Answer is taken at the rising edge where ack or err is sampled high
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
        if (ack !== 1'b1 && err !== 1'b1) fail_count++;
        rd = dat_o[7:0];
        e  = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic stop_test;
        if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    function automatic logic [7:0] pin_exp(input logic [7:0] c, input logic [7:0] d);
        return {7'h0, c[6] & d[2]};
    endfunction : pin_exp

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h2EF5));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        ctl = 8'h00;
        bus(1'b0, CA, 8'h00, 1'b1);
        `CHK("ctrl_rst", 8'h00, rd)
        for (int i = 0; i < 40; i++) begin
            v = (i == 0) ? 8'hFF : ((i == 1) ? 8'h10 : 8'($urandom));
            s = (i % 5 != 4);
            bus(1'b1, CA, v, s);
            if (s) ctl = v & vrc_pkg::CTRL_WRITE_MASK;
            cm = (i < 8) ? 8'(i) : 8'($urandom % 8);
            bus(1'b1, 32'(vrc_pkg::CMP_MODE_ADDR), cm, 1'b1);
            dir = 8'($urandom) & 8'h1F;
            bus(1'b1, 32'(vrc_pkg::PORT_DIR_ADDR), dir, 1'b1);
            bus(1'b0, CA, 8'h00, 1'b1);
            // Ladder outputs are looked at only after several bus cycles of settling
            `CHK("ctrl_rd", ctl, rd)
            `CHK("power", ctl[7], pwr)
            `CHK("range", ctl[5], rng)
            `CHK("tap", ctl[3:0], tap)
            `CHK("pin", pin_exp(ctl, dir), {7'h0, pin})
            `CHK("cmp", cm == 8'h02, cmp)
            bus(1'b0, 32'(vrc_pkg::LADDER_STAT_ADDR), 8'h00, 1'b1);
            `CHK("stat", {ctl[7], ctl[6] & dir[2], ctl[5], cm == 8'h02, ctl[3:0]}, rd)
        end
        // Power bit is dropped before the device would go to sleep
        bus(1'b1, CA, ctl & 8'h7F, 1'b1);
        ctl = ctl & 8'h6F;
        `CHK("pwr_off", 1'b0, pwr)
        bus(1'b1, 32'h00000100, 8'hFF, 1'b1);
        `CHK("err", 1'b1, e)
        bus(1'b0, CA, 8'h00, 1'b1);
        `CHK("ctrl_kept", ctl, rd)
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, CA, 8'h00, 1'b1);
        `CHK("ctrl_rst2", 8'h00, rd)
        `CHK("tap_rst2", 4'h0, tap)
        stop_test();
    end
endmodule : vrc_top_tb_top
